// [src/bridge_regs_defines.svh]
// Purpose: Offsets, field positions and reset values of the bridge window and secondary status registers
// Assumes: Register byte address is four times the register index
// Notes:   Definitions only
`ifndef BRIDGE_REGS_DEFINES_SVH
`define BRIDGE_REGS_DEFINES_SVH

`define ADDR_W          10
`define DATA_W          16
`define IDX_LATENCY     8'h1B
`define IDX_IO_BASE     8'h1C
`define IDX_IO_LIMIT    8'h1D
`define IDX_SEC_STATUS  8'h1E
`define IDX_MEM_BASE    8'h20
`define IDX_MEM_LIMIT   8'h22
`define IDX_BRIDGE_CTRL 8'h3E
`define IDX_IRQ_MASK    8'h40

`define BIT_IO_CAP      0
`define BIT_SYS_ERR     14
`define BIT_PARITY_ERR  15
`define BIT_SERR_EN     1

`define RST_LATENCY     8'h00
`define RST_IO_CAP      1'b1
`define RST_IO_BASE     4'hF
`define RST_IO_LIMIT    4'h0
`define RST_MEM_BASE    12'hFFF
`define RST_MEM_LIMIT   12'h000
`define RST_SERR_EN     1'b0
`define RST_IRQ_MASK    2'h0

`define IO_FIELD_W      4
`define IO_LOW_W        12
`define MEM_FIELD_W     12
`define MEM_LOW_W       20

`endif

// [src/bridge_regs_pkg.sv]
// Purpose: Types shared by the bridge register bank
// Assumes: Constants come from the defines header
// Notes:   Register select is decoded once and reused for read and write
package bridge_regs_pkg;

   typedef enum {
      SEL_NONE,
      SEL_LATENCY,
      SEL_IO_BASE,
      SEL_IO_LIMIT,
      SEL_SEC_STATUS,
      SEL_MEM_BASE,
      SEL_MEM_LIMIT,
      SEL_BRIDGE_CTRL,
      SEL_IRQ_MASK
   } reg_sel_t;

   typedef logic [15:0] reg_word_t;

endpackage : bridge_regs_pkg

// [src/window_match.sv]
// Purpose: Inclusive base/limit address window compare
// Assumes: Address width equals field width plus low bit count
// Notes:   Combinational; the caller registers the result
`timescale 1ns/1ps
module window_match #(
   parameter int FW = 4,
   parameter int LW = 12
) (
   input  wire logic [FW-1:0]    base_field,
   input  wire logic [FW-1:0]    limit_field,
   input  wire logic [FW+LW-1:0] addr,
   output logic                  hit
);

   logic [FW+LW-1:0] base_exp;
   logic [FW+LW-1:0] limit_exp;

   always_comb begin
      base_exp  = {base_field, {LW{1'b0}}};
      limit_exp = {limit_field, {LW{1'b1}}};
      // A base above the limit closes the window
      hit = (base_field <= limit_field) && (addr >= base_exp) && (addr <= limit_exp);
   end

endmodule : window_match

// [src/sticky_flag.sv]
// Purpose: Sticky event flag with write-one-to-clear
// Assumes: Set and clear are one-cycle pulses on the system clock
// Notes:   Set wins over a clear in the same cycle so no event is lost
`timescale 1ns/1ps
module sticky_flag (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set,
   input  wire logic clear,
   output logic      flag
);

   logic flag_next;

   always_comb begin
      flag_next = flag;
      if (set) begin
         flag_next = 1'b1;
      end else if (clear) begin
         flag_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else begin
         flag <= flag_next;
      end
   end

endmodule : sticky_flag

// [src/bridge_window_regs.sv]
// Purpose: Bridge window and secondary status configuration registers with forwarding decode
// Assumes: Inputs synchronous to CLK_SYS; request and event inputs are one-cycle pulses
// Notes:   Forward decisions appear one cycle after the request; the interrupt appears two cycles after the event
//
// Behaviour
// - Secondary latency byte is read-only and always reads zero.
// - I/O capability bit resets to one, lockable writable; one means 32-bit.
// - I/O limit bit 0 is read-only and mirrors the capability bit.
// - I/O base bits 7:4 give address 15:12, reset 0xF, bits 3:1 zero.
// - I/O limit bits 7:4 give top address 15:12, low bits ones, reset zero.
// - I/O forwarding is decided by the I/O base and limit window.
// - Secondary status bits 8 to 13 are read-only zero.
// - Received system error flag never sets while forwarding enable is clear.
// - With enable set, a received fatal or nonfatal message sets bit 14.
// - A poisoned packet on the secondary side always sets bit 15.
// - Memory base bits 15:4 give address 31:20, reset 0xFFF, bits 3:0 zero.
// - Memory forwarding is decided by the memory base and limit window.
// - Memory limit gives top address 31:20 with low twenty bits all ones.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "bridge_regs_defines.svh"
module bridge_window_regs
   import bridge_regs_pkg::*;
(
   input  wire logic               CLK_SYS,
   input  wire logic               RESETN,
   input  wire logic [`ADDR_W-1:0] REG_ADDR,
   input  wire logic [`DATA_W-1:0] REG_WDATA,
   input  wire logic               REG_WR,
   input  wire logic               REG_RD,
   output logic      [`DATA_W-1:0] REG_RDATA,
   input  wire logic               CAP_LOCK,
   input  wire logic               SEC_ERR_MSG,
   input  wire logic               SEC_POISONED_TLP,
   input  wire logic               IO_REQ_VALID,
   input  wire logic [31:0]        IO_REQ_ADDR,
   output logic                    IO_FWD_VALID,
   output logic                    IO_FWD,
   input  wire logic               MEM_REQ_VALID,
   input  wire logic [31:0]        MEM_REQ_ADDR,
   output logic                    MEM_FWD_VALID,
   output logic                    MEM_FWD,
   output logic                    IRQ
);

   reg_sel_t                  sel;
   logic                      io_cap_reg;
   logic                      io_cap_next;
   logic [`IO_FIELD_W-1:0]    io_base_reg;
   logic [`IO_FIELD_W-1:0]    io_base_next;
   logic [`IO_FIELD_W-1:0]    io_limit_reg;
   logic [`IO_FIELD_W-1:0]    io_limit_next;
   logic [`MEM_FIELD_W-1:0]   mem_base_reg;
   logic [`MEM_FIELD_W-1:0]   mem_base_next;
   logic [`MEM_FIELD_W-1:0]   mem_limit_reg;
   logic [`MEM_FIELD_W-1:0]   mem_limit_next;
   logic                      serr_en_reg;
   logic                      serr_en_next;
   logic [1:0]                irq_mask_reg;
   logic [1:0]                irq_mask_next;
   reg_word_t                 rdata_reg;
   reg_word_t                 rdata_next;
   logic                      sys_err_flag;
   logic                      parity_flag;
   logic                      status_wr;
   logic                      io_hit_low;
   logic                      mem_hit;
   logic                      io_hit;
   logic                      io_fwd_valid_reg;
   logic                      io_fwd_valid_next;
   logic                      io_fwd_reg;
   logic                      io_fwd_next;
   logic                      mem_fwd_valid_reg;
   logic                      mem_fwd_valid_next;
   logic                      mem_fwd_reg;
   logic                      mem_fwd_next;
   logic                      irq_reg;
   logic                      irq_next;

   // Address decode; misaligned byte addresses hit nothing
   always_comb begin
      sel = SEL_NONE;
      if (REG_ADDR[1:0] != 2'h0) begin
         sel = SEL_NONE;
      end else if (REG_ADDR[`ADDR_W-1:2] == `IDX_LATENCY) begin
         sel = SEL_LATENCY;
      end else if (REG_ADDR[`ADDR_W-1:2] == `IDX_IO_BASE) begin
         sel = SEL_IO_BASE;
      end else if (REG_ADDR[`ADDR_W-1:2] == `IDX_IO_LIMIT) begin
         sel = SEL_IO_LIMIT;
      end else if (REG_ADDR[`ADDR_W-1:2] == `IDX_SEC_STATUS) begin
         sel = SEL_SEC_STATUS;
      end else if (REG_ADDR[`ADDR_W-1:2] == `IDX_MEM_BASE) begin
         sel = SEL_MEM_BASE;
      end else if (REG_ADDR[`ADDR_W-1:2] == `IDX_MEM_LIMIT) begin
         sel = SEL_MEM_LIMIT;
      end else if (REG_ADDR[`ADDR_W-1:2] == `IDX_BRIDGE_CTRL) begin
         sel = SEL_BRIDGE_CTRL;
      end else if (REG_ADDR[`ADDR_W-1:2] == `IDX_IRQ_MASK) begin
         sel = SEL_IRQ_MASK;
      end
   end

   // Configuration writes
   always_comb begin
      io_cap_next    = io_cap_reg;
      io_base_next   = io_base_reg;
      io_limit_next  = io_limit_reg;
      mem_base_next  = mem_base_reg;
      mem_limit_next = mem_limit_reg;
      serr_en_next   = serr_en_reg;
      irq_mask_next  = irq_mask_reg;
      if (REG_WR) begin
         case (sel)
            SEL_IO_BASE: begin
               io_base_next = REG_WDATA[7:4];
               // Capability stays frozen while the lock is held
               if (!CAP_LOCK) begin
                  io_cap_next = REG_WDATA[`BIT_IO_CAP];
               end
            end
            SEL_IO_LIMIT: begin
               io_limit_next = REG_WDATA[7:4];
            end
            SEL_MEM_BASE: begin
               mem_base_next = REG_WDATA[15:4];
            end
            SEL_MEM_LIMIT: begin
               mem_limit_next = REG_WDATA[15:4];
            end
            SEL_BRIDGE_CTRL: begin
               serr_en_next = REG_WDATA[`BIT_SERR_EN];
            end
            SEL_IRQ_MASK: begin
               irq_mask_next = REG_WDATA[`BIT_PARITY_ERR:`BIT_SYS_ERR];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         io_cap_reg    <= `RST_IO_CAP;
         io_base_reg   <= `RST_IO_BASE;
         io_limit_reg  <= `RST_IO_LIMIT;
         mem_base_reg  <= `RST_MEM_BASE;
         mem_limit_reg <= `RST_MEM_LIMIT;
         serr_en_reg   <= `RST_SERR_EN;
         irq_mask_reg  <= `RST_IRQ_MASK;
      end else begin
         io_cap_reg    <= io_cap_next;
         io_base_reg   <= io_base_next;
         io_limit_reg  <= io_limit_next;
         mem_base_reg  <= mem_base_next;
         mem_limit_reg <= mem_limit_next;
         serr_en_reg   <= serr_en_next;
         irq_mask_reg  <= irq_mask_next;
      end
   end

   // Secondary status error flags double as interrupt status
   assign status_wr = REG_WR && (sel == SEL_SEC_STATUS);

   sticky_flag u_sys_err (
      .clk   (CLK_SYS),
      .rst_n (RESETN),
      .set   (SEC_ERR_MSG && serr_en_reg),
      .clear (status_wr && REG_WDATA[`BIT_SYS_ERR]),
      .flag  (sys_err_flag)
   );

   sticky_flag u_parity (
      .clk   (CLK_SYS),
      .rst_n (RESETN),
      .set   (SEC_POISONED_TLP),
      .clear (status_wr && REG_WDATA[`BIT_PARITY_ERR]),
      .flag  (parity_flag)
   );

   // Read data live only in the cycle after the strobe
   always_comb begin
      rdata_next = 16'h0000;
      if (REG_RD) begin
         case (sel)
            SEL_LATENCY:     rdata_next = {8'h00, `RST_LATENCY};
            SEL_IO_BASE:     rdata_next = {8'h00, io_base_reg, 3'h0, io_cap_reg};
            SEL_IO_LIMIT:    rdata_next = {8'h00, io_limit_reg, 3'h0, io_cap_reg};
            SEL_SEC_STATUS:  rdata_next = {parity_flag, sys_err_flag, 14'h0000};
            SEL_MEM_BASE:    rdata_next = {mem_base_reg, 4'h0};
            SEL_MEM_LIMIT:   rdata_next = {mem_limit_reg, 4'h0};
            SEL_BRIDGE_CTRL: rdata_next = {14'h0000, serr_en_reg, 1'b0};
            SEL_IRQ_MASK:    rdata_next = {irq_mask_reg, 14'h0000};
            default:         rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   window_match #(
      .FW (`IO_FIELD_W),
      .LW (`IO_LOW_W)
   ) u_io_win (
      .base_field  (io_base_reg),
      .limit_field (io_limit_reg),
      .addr        (IO_REQ_ADDR[15:0]),
      .hit         (io_hit_low)
   );

   window_match #(
      .FW (`MEM_FIELD_W),
      .LW (`MEM_LOW_W)
   ) u_mem_win (
      .base_field  (mem_base_reg),
      .limit_field (mem_limit_reg),
      .addr        (MEM_REQ_ADDR),
      .hit         (mem_hit)
   );

   // Upper I/O base and limit are not held here, so 32-bit mode takes them as zero
   assign io_hit = io_hit_low && (!io_cap_reg || (IO_REQ_ADDR[31:16] == 16'h0000));

   always_comb begin
      io_fwd_valid_next  = IO_REQ_VALID;
      io_fwd_next        = IO_REQ_VALID && io_hit;
      mem_fwd_valid_next = MEM_REQ_VALID;
      mem_fwd_next       = MEM_REQ_VALID && mem_hit;
      irq_next           = |({parity_flag, sys_err_flag} & irq_mask_reg);
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         io_fwd_valid_reg  <= 1'b0;
         io_fwd_reg        <= 1'b0;
         mem_fwd_valid_reg <= 1'b0;
         mem_fwd_reg       <= 1'b0;
         irq_reg           <= 1'b0;
      end else begin
         io_fwd_valid_reg  <= io_fwd_valid_next;
         io_fwd_reg        <= io_fwd_next;
         mem_fwd_valid_reg <= mem_fwd_valid_next;
         mem_fwd_reg       <= mem_fwd_next;
         irq_reg           <= irq_next;
      end
   end

   assign REG_RDATA     = rdata_reg;
   assign IO_FWD_VALID  = io_fwd_valid_reg;
   assign IO_FWD        = io_fwd_reg;
   assign MEM_FWD_VALID = mem_fwd_valid_reg;
   assign MEM_FWD       = mem_fwd_reg;
   assign IRQ           = irq_reg;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);

   sequence s_read_status;
      REG_RD && (sel == SEL_SEC_STATUS);
   endsequence

   sequence s_io_closed_req;
      IO_REQ_VALID && (io_base_reg > io_limit_reg);
   endsequence

   sequence s_sys_err_raise;
      sys_err_flag ##1 (IRQ || !$past(irq_mask_reg[0]));
   endsequence

   property p_latency_zero;
      REG_RD && (sel == SEL_LATENCY) |=> (REG_RDATA == 16'h0000);
   endproperty
   a_latency_zero: assert property (p_latency_zero) else $error("latency byte not zero");
   property p_cap_write;
      REG_WR && (sel == SEL_IO_BASE) |=> (io_cap_reg == ($past(CAP_LOCK) ? $past(io_cap_reg) : $past(REG_WDATA[0])));
   endproperty
   a_cap_write: assert property (p_cap_write) else $error("capability bit write wrong");
   property p_limit_mirror;
      REG_RD && (sel == SEL_IO_LIMIT) |=> (REG_RDATA[0] == $past(io_cap_reg)) && (REG_RDATA[3:1] == 3'h0);
   endproperty
   a_limit_mirror: assert property (p_limit_mirror) else $error("limit bit 0 not mirroring");
   property p_io_base_read;
      REG_RD && (sel == SEL_IO_BASE) |=> (REG_RDATA[7:4] == $past(io_base_reg)) && (REG_RDATA[3:1] == 3'h0);
   endproperty
   a_io_base_read: assert property (p_io_base_read) else $error("io base read wrong");
   property p_io_limit_write;
      REG_WR && (sel == SEL_IO_LIMIT) |=> (io_limit_reg == $past(REG_WDATA[7:4]));
   endproperty
   a_io_limit_write: assert property (p_io_limit_write) else $error("io limit write lost");
   property p_io_fwd16;
      IO_REQ_VALID && !io_cap_reg && (IO_REQ_ADDR[15:12] >= io_base_reg) && (IO_REQ_ADDR[15:12] <= io_limit_reg)
         |=> IO_FWD_VALID && IO_FWD;
   endproperty
   a_io_fwd16: assert property (p_io_fwd16) else $error("io in window not forwarded");
   property p_status_ro;
      s_read_status |=> (REG_RDATA[13:0] == 14'h0000);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status low bits not zero");
   property p_sys_err_gated;
      !serr_en_reg && !sys_err_flag |=> !sys_err_flag;
   endproperty
   a_sys_err_gated: assert property (p_sys_err_gated) else $error("system error flag set while disabled");
   // Interrupt is judged against the mask as it stood when the flag rose
   property p_sys_err_set;
      SEC_ERR_MSG && serr_en_reg |=> s_sys_err_raise;
   endproperty
   a_sys_err_set: assert property (p_sys_err_set) else $error("system error flag or interrupt not raised");
   property p_parity_set;
      SEC_POISONED_TLP |=> parity_flag;
   endproperty
   a_parity_set: assert property (p_parity_set) else $error("parity flag not set");
   property p_mem_base_read;
      REG_RD && (sel == SEL_MEM_BASE) |=> (REG_RDATA == {$past(mem_base_reg), 4'h0});
   endproperty
   a_mem_base_read: assert property (p_mem_base_read) else $error("mem base read wrong");
   property p_mem_fwd;
      MEM_REQ_VALID && (MEM_REQ_ADDR[31:20] >= mem_base_reg) && (MEM_REQ_ADDR[31:20] <= mem_limit_reg)
         |=> MEM_FWD_VALID && MEM_FWD;
   endproperty
   a_mem_fwd: assert property (p_mem_fwd) else $error("mem in window not forwarded");
   property p_w1c;
      REG_WR && (sel == SEL_SEC_STATUS) && REG_WDATA[15] && !SEC_POISONED_TLP |=> !parity_flag;
   endproperty
   a_w1c: assert property (p_w1c) else $error("parity flag not cleared by write one");
   property p_closed;
      s_io_closed_req |=> IO_FWD_VALID && !IO_FWD;
   endproperty
   a_closed: assert property (p_closed) else $error("closed window forwarded");

endmodule : bridge_window_regs

// [sim/cfg_host_model.sv]
// Purpose: Upstream configuration master driving the register port
// Assumes: Slave never stalls; read data stands only in the cycle after the read
// Notes:   Released address and data are inverted so stale values never pass as live
`timescale 1ns/1ps
`include "bridge_regs_defines.svh"
module cfg_host_model (
   input  wire logic               clk,
   output logic      [`ADDR_W-1:0] addr,
   output logic      [`DATA_W-1:0] wdata,
   output logic                    wr,
   output logic                    rd,
   input  wire logic [`DATA_W-1:0] rdata
);
   initial begin
      addr  = '0;
      wdata = '0;
      wr    = 1'b0;
      rd    = 1'b0;
   end

   task automatic write_reg(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~d;
   endtask : write_reg

   task automatic read_reg(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      addr <= ~a;
      // Data stands one cycle only, so it is taken just after the answering edge
      #1 d = rdata;
   endtask : read_reg
endmodule : cfg_host_model

// [sim/bridge_window_regs_test.sv]
// Purpose: Self-checking bench for the bridge window and secondary status registers
// Assumes: 10 MHz clock, asynchronous active-low reset
// Notes:   Expected values are worked out here from the register layout
`timescale 1ns/1ps
`include "bridge_regs_defines.svh"
module bridge_window_regs_test;
   logic               clk_sys = 1'b0;
   logic               resetn = 1'b0;
   logic [`ADDR_W-1:0] reg_addr;
   logic [`DATA_W-1:0] reg_wdata;
   logic               reg_wr;
   logic               reg_rd;
   logic [`DATA_W-1:0] reg_rdata;
   logic               cap_lock = 1'b0;
   logic               err_msg = 1'b0;
   logic               poison = 1'b0;
   logic               io_vld = 1'b0;
   logic [31:0]        io_addr = 32'h0000_0000;
   logic               io_fwd_vld;
   logic               io_fwd;
   logic               mem_vld = 1'b0;
   logic [31:0]        mem_addr = 32'h0000_0000;
   logic               mem_fwd_vld;
   logic               mem_fwd;
   logic               irq;
   int                 mismatches = 0;
   int                 check_count = 0;

   always #50 clk_sys = ~clk_sys;

   cfg_host_model i_host (.clk(clk_sys), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd),
                          .rdata(reg_rdata));

   bridge_window_regs i_dut (.CLK_SYS(clk_sys), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CAP_LOCK(cap_lock), .SEC_ERR_MSG(err_msg),
      .SEC_POISONED_TLP(poison), .IO_REQ_VALID(io_vld), .IO_REQ_ADDR(io_addr), .IO_FWD_VALID(io_fwd_vld),
      .IO_FWD(io_fwd), .MEM_REQ_VALID(mem_vld), .MEM_REQ_ADDR(mem_addr), .MEM_FWD_VALID(mem_fwd_vld),
      .MEM_FWD(mem_fwd), .IRQ(irq));

   task automatic chk(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] exp);
      logic [`DATA_W-1:0] d;
      i_host.read_reg(a, d);
      chk(d, exp);
   endtask : rd_chk

   task automatic fwd_chk(input logic is_io, input logic [31:0] a, input logic exp);
      @(posedge clk_sys);
      io_vld   <= is_io;
      io_addr  <= a;
      mem_vld  <= ~is_io;
      mem_addr <= a;
      @(posedge clk_sys);
      io_vld  <= 1'b0;
      mem_vld <= 1'b0;
      #1;
      chk({14'h0000, (is_io ? io_fwd_vld : mem_fwd_vld), (is_io ? io_fwd : mem_fwd)}, {15'h0001, exp});
   endtask : fwd_chk

   task automatic pulse_event(input logic is_err);
      @(posedge clk_sys);
      err_msg <= is_err;
      poison  <= ~is_err;
      @(posedge clk_sys);
      err_msg <= 1'b0;
      poison  <= 1'b0;
   endtask : pulse_event

   task automatic test_reset_values;
      rd_chk(10'h06C, 16'h0000);
      rd_chk(10'h070, 16'h00F1);
      rd_chk(10'h074, 16'h0001);
      rd_chk(10'h078, 16'h0000);
      rd_chk(10'h080, 16'hFFF0);
   endtask : test_reset_values

   task automatic test_access;
      i_host.write_reg(10'h06C, 16'hFFFF);
      rd_chk(10'h06C, 16'h0000);
      i_host.write_reg(10'h070, 16'h005E);
      rd_chk(10'h070, 16'h0050);
      rd_chk(10'h074, 16'h0000);
      i_host.write_reg(10'h074, 16'hFFAF);
      rd_chk(10'h074, 16'h00A0);
      @(posedge clk_sys);
      cap_lock <= 1'b1;
      i_host.write_reg(10'h070, 16'h0051);
      rd_chk(10'h070, 16'h0050);
      @(posedge clk_sys);
      cap_lock <= 1'b0;
      i_host.write_reg(10'h078, 16'h3FFF);
      rd_chk(10'h078, 16'h0000);
      i_host.write_reg(10'h080, 16'h123F);
      rd_chk(10'h080, 16'h1230);
      i_host.write_reg(10'h088, 16'h1240);
      rd_chk(10'h088, 16'h1240);
      i_host.write_reg(10'h084, 16'hFFFF);
      rd_chk(10'h084, 16'h0000);
      rd_chk(10'h082, 16'h0000);
   endtask : test_access

   task automatic test_windows;
      fwd_chk(1'b1, 32'h0000_5000, 1'b1);
      fwd_chk(1'b1, 32'h0000_4FFF, 1'b0);
      fwd_chk(1'b1, 32'h0001_AFFF, 1'b1);
      fwd_chk(1'b1, 32'h0000_B000, 1'b0);
      fwd_chk(0, 32'h1230_0000, 1'b1);
      fwd_chk(0, 32'h122F_FFFF, 1'b0);
      fwd_chk(0, 32'h124F_FFFF, 1'b1);
      fwd_chk(0, 32'h1250_0000, 1'b0);
      i_host.write_reg(10'h070, 16'h0051);
      fwd_chk(1'b1, 32'h0001_5000, 1'b0);
      fwd_chk(1'b1, 32'h0000_5000, 1'b1);
      i_host.write_reg(10'h080, 16'h2000);
      fwd_chk(0, 32'h1500_0000, 1'b0);
      i_host.write_reg(10'h070, 16'h00B0);
      fwd_chk(1'b1, 32'h0000_B000, 1'b0);
   endtask : test_windows

   task automatic test_events;
      pulse_event(1'b1);
      rd_chk(10'h078, 16'h0000);
      i_host.write_reg(10'h0F8, 16'h0002);
      rd_chk(10'h0F8, 16'h0002);
      pulse_event(1'b1);
      rd_chk(10'h078, 16'h4000);
      pulse_event(1'b0);
      rd_chk(10'h078, 16'hC000);
      i_host.write_reg(10'h078, 16'h4000);
      rd_chk(10'h078, 16'h8000);
      i_host.write_reg(10'h078, 16'h0000);
      rd_chk(10'h078, 16'h8000);
      i_host.write_reg(10'h078, 16'h8000);
      rd_chk(10'h078, 16'h0000);
      // Masked event must leave the interrupt low
      pulse_event(1'b0);
      @(posedge clk_sys);
      #1 chk({15'h0000, irq}, 16'h0000);
      i_host.write_reg(10'h100, 16'h8000);
      @(posedge clk_sys);
      #1 chk({15'h0000, irq}, 16'h0001);
      i_host.write_reg(10'h078, 16'h8000);
      @(posedge clk_sys);
      #1 chk({15'h0000, irq}, 16'h0000);
      i_host.write_reg(10'h100, 16'hC000);
      rd_chk(10'h100, 16'hC000);
      pulse_event(1'b1);
      @(posedge clk_sys);
      #1 chk({15'h0000, irq}, 16'h0001);
   endtask : test_events

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      test_reset_values();
      test_access();
      test_windows();
      test_events();
      print_verdict();
   end

   // Whole run is under 150 cycles; 20000 leaves ample margin
   initial begin
      #2_000_000;
      mismatches++;
      print_verdict();
   end
endmodule : bridge_window_regs_test
